// [shared/sample_fifo_pkg.sv]
// constants shared by the sample stream input fifo and its helpers
package sample_fifo_pkg;

   // fifo geometry
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam logic [FIFO_AW+1:0] DEPTH_LVL = 6'h10;

   // stream word and sideband layout
   localparam int WORD_W_DEF = 32;
   localparam int LANE_W = 16;
   localparam int TUSER_W = 80;
   localparam int TS_LSB = 0;
   localparam int TS_W = 64;
   localparam int BEGIN_BIT = 64;
   localparam int FMT_LSB = 65;
   localparam int FMT_W = 2;
   localparam int IQ_BIT = 67;
   localparam int CHAN_LSB = 68;
   localparam int CHAN_W = 8;
   localparam int UBITS_LSB = 76;
   localparam int UBITS_W = 4;

   // sample format codes, in sideband order
   typedef enum logic [1:0] {FMT_8, FMT_16, FMT_24, FMT_32} fmt_t;
   localparam logic [5:0] SAMPLE_BITS_8 = 6'h08;
   localparam logic [5:0] SAMPLE_BITS_16 = 6'h10;
   localparam logic [5:0] SAMPLE_BITS_24 = 6'h18;
   localparam logic [5:0] SAMPLE_BITS_32 = 6'h20;

   // packet tracking
   typedef enum logic {PKT_IDLE, PKT_BODY} pkt_state_t;

   // apb register map, byte addresses
   localparam int APB_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
   localparam logic [7:0] REG_PKT_INFO = 8'h10;
   localparam logic [7:0] REG_TS_LO = 8'h14;
   localparam logic [7:0] REG_TS_HI = 8'h18;
   localparam logic [7:0] REG_DROP_CNT = 8'h1c;

   // control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_IGN_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

   // status fields
   localparam int ST_READY_BIT = 0;
   localparam int ST_FULL_BIT = 1;
   localparam int ST_EMPTY_BIT = 2;
   localparam int ST_INPKT_BIT = 3;
   localparam int ST_LEVEL_LSB = 8;

   // event bits, shared by irq status and mask
   localparam int EV_W = 3;
   localparam int EV_OVF = 0;
   localparam int EV_END = 1;
   localparam int EV_FRAME = 2;

   // packet info fields
   localparam int INFO_FMT_LSB = 0;
   localparam int INFO_IQ_BIT = 2;
   localparam int INFO_CHAN_LSB = 8;
   localparam int INFO_UBITS_LSB = 16;
   localparam int INFO_BITS_LSB = 24;

endpackage

// [hw/bit_sync.sv]
// two flip-flop synchroniser for a group of slow or asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;
endmodule
`default_nettype wire

// [hw/word_fifo.sv]
// single clock word fifo with fill level, full and empty
`timescale 1ns/10ps
`default_nettype none
module word_fifo
   import sample_fifo_pkg::*;
#(
   parameter int FW = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // write side
   input wire logic i_wr_en,
   input wire logic [FW-1:0] i_wr_data,
   output logic o_full,
   // read side
   input wire logic i_rd_en,
   output logic [FW-1:0] o_rd_data,
   output logic o_empty,
   output logic [FIFO_AW:0] o_level
);
   logic [FW-1:0] mem [FIFO_DEPTH];
   logic [FIFO_AW:0] wr_ptr_ff;
   logic [FIFO_AW:0] rd_ptr_ff;

   // storage needs no reset; pointers define what is valid
   always_ff @(posedge i_clk)
   begin
      if (i_wr_en && !o_full)
      begin
         mem[wr_ptr_ff[FIFO_AW-1:0]] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         wr_ptr_ff <= '0;
      end
      else if (i_wr_en && !o_full)
      begin
         wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         rd_ptr_ff <= '0;
      end
      else if (i_rd_en && !o_empty)
      begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end

   assign o_level = wr_ptr_ff - rd_ptr_ff;
   assign o_full = (wr_ptr_ff[FIFO_AW] != rd_ptr_ff[FIFO_AW]) &&
      (wr_ptr_ff[FIFO_AW-1:0] == rd_ptr_ff[FIFO_AW-1:0]);
   assign o_empty = (wr_ptr_ff == rd_ptr_ff);
   assign o_rd_data = mem[rd_ptr_ff[FIFO_AW-1:0]];
endmodule
`default_nettype wire

// [hw/sample_stream_input_fifo.sv]
// sample stream input fifo: stream slave, packet tracking, apb registers
//
// Operation
// - packet begin flag and last beat together delimit one acquisition
// - sideband 66:65 give sample size: 8, 16, 24 or 32 bits
// - sideband bit 67: zero is real, one is complex i/q
// - user bits 79:76 are used only on the last beat
// - stream word width is a build-time parameter
// - each keep bit qualifies one 16-bit lane, bit 0 lowest
// - ready only while the fifo has room for another word
// - stream has its own clock and active-low reset
`timescale 1ns/10ps
`default_nettype none
module sample_stream_input_fifo
   import sample_fifo_pkg::*;
#(
   parameter int WORD_W = WORD_W_DEF
) (
   // core clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET_N,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [APB_AW-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // interrupt
   output logic O_IRQ,
   // sample stream from the source, on its own clock
   input wire logic I_STREAM_CLK,
   input wire logic I_STREAM_RESET_N,
   input wire logic [WORD_W-1:0] I_TDATA,
   input wire logic [WORD_W/LANE_W-1:0] I_TKEEP,
   input wire logic [TUSER_W-1:0] I_TUSER,
   input wire logic I_TVALID,
   input wire logic I_TLAST,
   output logic O_TREADY,
   // words toward the dma core
   output logic O_OUT_VALID,
   input wire logic I_OUT_READY,
   output logic [WORD_W-1:0] O_OUT_DATA,
   output logic [WORD_W/LANE_W-1:0] O_OUT_KEEP,
   output logic O_OUT_LAST,
   output logic O_OUT_BEGIN,
   output logic [TS_W-1:0] O_OUT_TIMESTAMP,
   output logic [5:0] O_OUT_SAMPLE_BITS,
   output logic O_OUT_IQ,
   output logic [CHAN_W-1:0] O_OUT_CHANNEL,
   output logic [UBITS_W-1:0] O_OUT_USER_BITS
);
   localparam int KEEP_W = WORD_W / LANE_W;
   localparam int BW = WORD_W + KEEP_W + TUSER_W + 2;
   localparam int FW = WORD_W + KEEP_W + TUSER_W + 1;

   // ---- stream side sampling ----
   logic [1:0] link_ctl_s;
   logic [BW-1:0] bundle_s;
   logic [BW-1:0] bundle_d_ff;
   logic clk_d_ff;
   logic link_clk_s;
   logic link_rst_n_s;
   logic edge_raw;
   logic edge_pulse;

   // the stream clock is only sampled; all its inputs get two stages
   bit_sync #(.W(2)) u_ctl_sync (
      .i_clk(I_SYS_CLK),
      .i_reset_n(I_RESET_N),
      .i_async({I_STREAM_RESET_N, I_STREAM_CLK}),
      .o_sync(link_ctl_s)
   );

   bit_sync #(.W(BW)) u_data_sync (
      .i_clk(I_SYS_CLK),
      .i_reset_n(I_RESET_N),
      .i_async({I_TLAST, I_TKEEP, I_TUSER, I_TVALID, I_TDATA}),
      .o_sync(bundle_s)
   );

   assign link_clk_s = link_ctl_s[0];
   assign link_rst_n_s = link_ctl_s[1];

   // data one sample older than the edge: taken while the clock was low,
   // so a source changing right after its edge is never caught midway
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         clk_d_ff <= 1'b0;
         bundle_d_ff <= '0;
      end
      else
      begin
         clk_d_ff <= link_clk_s;
         bundle_d_ff <= bundle_s;
      end
   end

   assign edge_raw = link_clk_s && !clk_d_ff;
   assign edge_pulse = edge_raw && link_rst_n_s;

   logic [WORD_W-1:0] s_data;
   logic s_valid;
   logic [TUSER_W-1:0] s_user;
   logic [KEEP_W-1:0] s_keep;
   logic s_last;

   assign s_data = bundle_d_ff[WORD_W-1:0];
   assign s_valid = bundle_d_ff[WORD_W];
   assign s_user = bundle_d_ff[WORD_W+1 +: TUSER_W];
   assign s_keep = bundle_d_ff[WORD_W+1+TUSER_W +: KEEP_W];
   assign s_last = bundle_d_ff[BW-1];

   // ---- control registers ----
   logic [31:0] ctrl_ff;
   logic [EV_W-1:0] irq_status_ff;
   logic [EV_W-1:0] irq_mask_ff;
   logic ctrl_en;
   logic ctrl_ign;

   assign ctrl_en = ctrl_ff[CTRL_EN_BIT];
   assign ctrl_ign = ctrl_ff[CTRL_IGN_BIT];

   // ---- accept, drop and ready ----
   logic fifo_full;
   logic fifo_empty;
   logic [FIFO_AW:0] fifo_level;
   logic fifo_rd;
   logic [FW-1:0] fifo_head;
   logic beat_seen;
   logic take;
   logic drop;
   logic tready_ff;
   logic [FIFO_AW+1:0] level_after;

   // a beat is on the bus at the edge when valid was sampled high
   assign beat_seen = edge_pulse && s_valid && ctrl_en;
   // honouring source: ready held since last edge decides the transfer;
   // free-running source: take whatever fits, drop the rest
   assign take = beat_seen && (ctrl_ign ? !fifo_full : tready_ff);
   assign drop = beat_seen && ctrl_ign && fifo_full;

   assign level_after = {1'b0, fifo_level} + {{(FIFO_AW+1){1'b0}}, take};

   // ready changes only just after a detected edge or when cleared by stream reset or disable, so it is stable for
   // the whole stream period; reads in between only add room
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         tready_ff <= 1'b0;
      end
      else if (!link_rst_n_s || !ctrl_en)
      begin
         tready_ff <= 1'b0;
      end
      else if (edge_raw)
      begin
         tready_ff <= (level_after < DEPTH_LVL);
      end
   end

   assign O_TREADY = tready_ff;

   // fifo entry: last, keep, sideband, data
   word_fifo #(.FW(FW)) u_fifo (
      .i_clk(I_SYS_CLK),
      .i_reset_n(I_RESET_N),
      .i_wr_en(take),
      .i_wr_data({s_last, s_keep, s_user, s_data}),
      .o_full(fifo_full),
      .i_rd_en(fifo_rd),
      .o_rd_data(fifo_head),
      .o_empty(fifo_empty),
      .o_level(fifo_level)
   );

   // ---- packet tracking ----
   pkt_state_t pkt_state_ff;
   logic frame_err;
   logic pkt_begin;

   assign pkt_begin = s_user[BEGIN_BIT];

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         pkt_state_ff <= PKT_IDLE;
      end
      else if (take)
      begin
         case (pkt_state_ff)
            PKT_IDLE: if (pkt_begin && !s_last) pkt_state_ff <= PKT_BODY;
            PKT_BODY: if (s_last) pkt_state_ff <= PKT_IDLE;
            default: pkt_state_ff <= PKT_IDLE;
         endcase
      end
   end

   // a begin inside a packet, or a beat outside one, breaks framing
   assign frame_err = take && ((pkt_state_ff == PKT_BODY) == pkt_begin);

   // ---- latched packet information ----
   logic [31:0] pkt_info_ff;
   logic [TS_W-1:0] ts_ff;
   logic [31:0] drop_cnt_ff;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         ts_ff <= '0;
      end
      else if (take && pkt_begin)
      begin
         ts_ff <= s_user[TS_LSB +: TS_W];
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         pkt_info_ff <= '0;
      end
      else if (take && s_last)
      begin
         pkt_info_ff <= '0;
         pkt_info_ff[INFO_FMT_LSB +: FMT_W] <= s_user[FMT_LSB +: FMT_W];
         pkt_info_ff[INFO_IQ_BIT] <= s_user[IQ_BIT];
         pkt_info_ff[INFO_CHAN_LSB +: CHAN_W] <= s_user[CHAN_LSB +: CHAN_W];
         pkt_info_ff[INFO_UBITS_LSB +: UBITS_W] <= s_user[UBITS_LSB +: UBITS_W];
         pkt_info_ff[INFO_BITS_LSB +: 6] <= sample_bits(s_user[FMT_LSB +: FMT_W]);
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         drop_cnt_ff <= '0;
      end
      else if (drop)
      begin
         drop_cnt_ff <= drop_cnt_ff + 32'h1;
      end
   end

   function automatic logic [5:0] sample_bits(input logic [1:0] code);
      case (fmt_t'(code))
         FMT_8: sample_bits = SAMPLE_BITS_8;
         FMT_16: sample_bits = SAMPLE_BITS_16;
         FMT_24: sample_bits = SAMPLE_BITS_24;
         FMT_32: sample_bits = SAMPLE_BITS_32;
         default: sample_bits = SAMPLE_BITS_8;
      endcase
   endfunction

   // ---- output stage toward the core ----
   logic out_valid_ff;
   logic [FW-1:0] out_word_ff;
   logic [TUSER_W-1:0] out_user;
   logic out_last;

   assign fifo_rd = !fifo_empty && (!out_valid_ff || I_OUT_READY);

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         out_valid_ff <= 1'b0;
      end
      else if (!out_valid_ff || I_OUT_READY)
      begin
         out_valid_ff <= !fifo_empty;
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         out_word_ff <= '0;
      end
      else if (fifo_rd)
      begin
         out_word_ff <= fifo_head;
      end
   end

   assign out_user = out_word_ff[WORD_W +: TUSER_W];
   assign out_last = out_word_ff[FW-1];

   assign O_OUT_VALID = out_valid_ff;
   assign O_OUT_DATA = out_word_ff[WORD_W-1:0];
   assign O_OUT_KEEP = out_word_ff[WORD_W+TUSER_W +: KEEP_W];
   assign O_OUT_LAST = out_last;
   assign O_OUT_BEGIN = out_user[BEGIN_BIT];
   assign O_OUT_TIMESTAMP = out_user[TS_LSB +: TS_W];
   assign O_OUT_IQ = out_user[IQ_BIT];
   assign O_OUT_CHANNEL = out_user[CHAN_LSB +: CHAN_W];

   // the decode and user gating sit behind flops so outputs stay registered
   logic [5:0] out_bits_ff;
   logic [UBITS_W-1:0] out_ubits_ff;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         out_bits_ff <= SAMPLE_BITS_8;
         out_ubits_ff <= '0;
      end
      else if (fifo_rd)
      begin
         out_bits_ff <= sample_bits(fifo_head[WORD_W+FMT_LSB +: FMT_W]);
         out_ubits_ff <= fifo_head[FW-1] ?
            fifo_head[WORD_W+UBITS_LSB +: UBITS_W] : '0;
      end
   end

   assign O_OUT_SAMPLE_BITS = out_bits_ff;
   assign O_OUT_USER_BITS = out_ubits_ff;

   // ---- apb slave ----
   logic access;
   logic wr_fire;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [31:0] status_word;

   assign access = I_PSEL && I_PENABLE;
   // writes land at the edge that completes the access
   assign wr_fire = access && pready_ff && I_PWRITE;

   always_comb
   begin
      status_word = '0;
      status_word[ST_READY_BIT] = tready_ff;
      status_word[ST_FULL_BIT] = fifo_full;
      status_word[ST_EMPTY_BIT] = fifo_empty;
      status_word[ST_INPKT_BIT] = (pkt_state_ff == PKT_BODY);
      status_word[ST_LEVEL_LSB +: FIFO_AW+1] = fifo_level;
   end

   always_comb
   begin
      rd_hit = 1'b1;
      rd_mux = '0;
      case (I_PADDR)
         REG_CTRL: rd_mux = ctrl_ff;
         REG_STATUS: rd_mux = status_word;
         REG_IRQ_STATUS: rd_mux[EV_W-1:0] = irq_status_ff;
         REG_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask_ff;
         REG_PKT_INFO: rd_mux = pkt_info_ff;
         REG_TS_LO: rd_mux = ts_ff[31:0];
         REG_TS_HI: rd_mux = ts_ff[63:32];
         REG_DROP_CNT: rd_mux = drop_cnt_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   // one wait state: ready rises in the second access cycle
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end
      else
      begin
         pready_ff <= access && !pready_ff;
         if (access && !pready_ff)
         begin
            pslverr_ff <= !rd_hit;
            prdata_ff <= I_PWRITE ? 32'h0 : rd_mux;
         end
      end
   end

   assign O_PREADY = pready_ff;
   assign O_PSLVERR = pslverr_ff;
   assign O_PRDATA = prdata_ff;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         ctrl_ff <= CTRL_RESET;
      end
      else if (wr_fire && I_PADDR == REG_CTRL)
      begin
         ctrl_ff <= '0;
         ctrl_ff[CTRL_EN_BIT] <= I_PWDATA[CTRL_EN_BIT];
         ctrl_ff[CTRL_IGN_BIT] <= I_PWDATA[CTRL_IGN_BIT];
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         irq_mask_ff <= '0;
      end
      else if (wr_fire && I_PADDR == REG_IRQ_MASK)
      begin
         irq_mask_ff <= I_PWDATA[EV_W-1:0];
      end
   end

   // ---- sticky events and interrupt ----
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;

   always_comb
   begin
      ev_set = '0;
      ev_set[EV_OVF] = drop;
      ev_set[EV_END] = take && s_last;
      ev_set[EV_FRAME] = frame_err;
   end

   assign ev_clr = (wr_fire && I_PADDR == REG_IRQ_STATUS) ?
      I_PWDATA[EV_W-1:0] : '0;

   // a new event wins over a clear in the same cycle
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         irq_status_ff <= '0;
      end
      else
      begin
         irq_status_ff <= (irq_status_ff & ~ev_clr) | ev_set;
      end
   end

   logic irq_ff;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= |(irq_status_ff & irq_mask_ff);
      end
   end

   assign O_IRQ = irq_ff;
endmodule
`default_nettype wire

// [testbench/fifo_props.sv]
// port assertions for the sample stream input fifo
`timescale 1ns/10ps
`default_nettype none
module fifo_props
   import sample_fifo_pkg::*;
#(
   parameter int WORD_W = WORD_W_DEF
) (
   // clocks and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET_N,
   input wire logic I_STREAM_CLK,
   // apb
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [APB_AW-1:0] I_PADDR,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   // stream and output side
   input wire logic O_TREADY,
   input wire logic O_OUT_VALID,
   input wire logic I_OUT_READY,
   input wire logic [WORD_W-1:0] O_OUT_DATA,
   input wire logic O_OUT_LAST,
   input wire logic [5:0] O_OUT_SAMPLE_BITS,
   input wire logic [UBITS_W-1:0] O_OUT_USER_BITS
);
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RESET_N);
   sequence setup_s;
      I_PSEL && !I_PENABLE;
   endsequence
   sequence access_s;
      I_PSEL && I_PENABLE;
   endsequence
   a_one_wait: assert property (setup_s ##1 access_s |=> O_PREADY)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (O_PREADY |-> access_s)
      else $error("pready outside access");
   a_err_map: assert property (O_PREADY && I_PADDR[1:0] == 2'b00
      |-> O_PSLVERR == (I_PADDR > REG_DROP_CNT))
      else $error("pslverr wrong for address");
   a_err_data: assert property (O_PREADY && (O_PSLVERR || I_PWRITE) |-> O_PRDATA == 32'h0)
      else $error("prdata not zero");
   a_ubits_last: assert property (
      O_OUT_VALID && !O_OUT_LAST |-> O_OUT_USER_BITS == 4'h0)
      else $error("user bits on non-last word");
   a_bits_legal: assert property (
      O_OUT_VALID |-> O_OUT_SAMPLE_BITS inside {6'h08, 6'h10, 6'h18, 6'h20})
      else $error("sample size not decoded");
   a_out_hold: assert property (
      O_OUT_VALID && !I_OUT_READY |=> O_OUT_VALID && $stable(O_OUT_DATA))
      else $error("output word changed while stalled");
   a_tready_edge: assert property (
      $changed(O_TREADY) |-> I_STREAM_CLK)
      else $error("tready moved away from stream edge");
endmodule
`default_nettype wire

// [testbench/sample_source.sv]
// stream source model: sends queued beats on the stream clock
`timescale 1ns/10ps
`default_nettype none
module sample_source
   import sample_fifo_pkg::*;
#(
   parameter int WORD_W = WORD_W_DEF
) (
   // stream clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // free running mode ignores ready
   input wire logic i_ign,
   // stream
   input wire logic i_tready,
   output logic [WORD_W-1:0] o_tdata,
   output logic [WORD_W/LANE_W-1:0] o_tkeep,
   output logic [TUSER_W-1:0] o_tuser,
   output logic o_tvalid,
   output logic o_tlast
);
   logic [WORD_W+WORD_W/LANE_W+TUSER_W:0] beat_q[$];
   function automatic void push(input logic [WORD_W+WORD_W/LANE_W+TUSER_W:0] b);
      beat_q.push_back(b);
   endfunction
   initial {o_tdata, o_tkeep, o_tuser, o_tlast, o_tvalid} = '0;
   always @(posedge i_clk)
   begin
      if (!i_reset_n || !o_tvalid || i_tready || i_ign)
      begin
         if (i_reset_n && beat_q.size() > 0)
         begin
            {o_tdata, o_tkeep, o_tuser, o_tlast} <= beat_q.pop_front();
            o_tvalid <= 1'b1;
         end
         else
         begin
            // idle lines toggle so a stale word never looks valid
            {o_tdata, o_tkeep, o_tuser, o_tlast} <= ~{o_tdata, o_tkeep, o_tuser, o_tlast};
            o_tvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the sample stream input fifo
`timescale 1ns/10ps
`default_nettype none
module tb
   import sample_fifo_pkg::*;
   ;
   logic sys_clk = 1'b0;
   logic strm_clk = 1'b0;
   logic out_ready = 1'b0;
   logic reset_n, psel, penable, pwrite, hold, ign;
   logic [7:0] paddr, ochan;
   logic [31:0] pwdata, prdata, tdata, odata, info;
   logic pready, pslverr, irq, tready, tvalid, tlast, ovalid, olast, obegin, oiq;
   logic [1:0] tkeep, okeep;
   logic [79:0] tuser;
   logic [63:0] ots, ts;
   logic [5:0] obits;
   logic [3:0] oubits;
   logic [118:0] exp_q[$];
   logic [32:0] rd_q[$];
   int n_fail = 0;
   int tests_run = 0;
   int seed = 28;
   int cyc = 0;
   int left;
   always #5 sys_clk = ~sys_clk;
   // stream clock on its own phase
   initial #3 forever #80 strm_clk = ~strm_clk;
   sample_stream_input_fifo #(.WORD_W(32)) u_dut (
      .I_SYS_CLK(sys_clk), .I_RESET_N(reset_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq), .I_STREAM_CLK(strm_clk),
      .I_STREAM_RESET_N(reset_n), .I_TDATA(tdata), .I_TKEEP(tkeep), .I_TUSER(tuser),
      .I_TVALID(tvalid), .I_TLAST(tlast), .O_TREADY(tready), .O_OUT_VALID(ovalid),
      .I_OUT_READY(out_ready), .O_OUT_DATA(odata), .O_OUT_KEEP(okeep), .O_OUT_LAST(olast),
      .O_OUT_BEGIN(obegin), .O_OUT_TIMESTAMP(ots), .O_OUT_SAMPLE_BITS(obits),
      .O_OUT_IQ(oiq), .O_OUT_CHANNEL(ochan), .O_OUT_USER_BITS(oubits));
   sample_source #(.WORD_W(32)) u_src (
      .i_clk(strm_clk), .i_reset_n(reset_n), .i_ign(ign), .i_tready(tready),
      .o_tdata(tdata), .o_tkeep(tkeep), .o_tuser(tuser), .o_tvalid(tvalid), .o_tlast(tlast));
   task automatic check(input logic [118:0] got, input logic [118:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] exp);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      if (!w)
         rd_q.push_back(exp);
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   task automatic send(input logic [79:0] u, input logic last, input logic [1:0] k);
      logic [31:0] d;
      d = $random(seed);
      u_src.push({d, k, u, last});
      exp_q.push_back({d, k, last, u[BEGIN_BIT], u[63:0], 6'(u[66:65] * 8 + 8), u[IQ_BIT],
         u[75:68], last ? u[79:76] : 4'h0});
   endtask
   task automatic pkt(input int n, input logic [1:0] f, input logic q);
      logic [79:0] u;
      for (int i = 0; i < n; i++)
      begin
         u = {4'($random(seed)), 8'($random(seed)), q, f, 1'(i == 0), 32'($random(seed)),
            32'($random(seed))};
         if (i == 0)
            ts = u[63:0];
         send(u, 1'(i == n - 1), i == n - 1 ? 2'($random(seed)) | 2'b01 : 2'b11);
      end
      info = {2'b00, 6'(f * 8 + 8), 4'h0, u[79:76], u[75:68], 5'h00, q, f};
   endtask
   always @(posedge sys_clk)
   begin
      if (reset_n && psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, rd_q.pop_front());
      if (reset_n && ovalid === 1'b1 && out_ready)
         check({odata, okeep, olast, obegin, ots, obits, oiq, ochan, oubits},
            exp_q.pop_front());
      out_ready <= hold ? 1'b0 : 1'($random(seed));
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end
   initial
   begin
      {reset_n, psel, penable, pwrite, hold, ign, paddr, pwdata} = '0;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0, {1'b0, CTRL_RESET});
      apb(1'b0, REG_IRQ_MASK, 32'h0, 33'h0);
      apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
      apb(1'b1, REG_DROP_CNT, 32'h7, 33'h0);
      apb(1'b0, REG_DROP_CNT, 32'h0, 33'h0);
      apb(1'b1, REG_IRQ_MASK, 32'h2, 33'h0);
      apb(1'b0, REG_IRQ_MASK, 32'h0, 33'h2);
      $display("test registers done");
      for (int f = 0; f < 4; f++)
         for (int q = 0; q < 2; q++)
            pkt(1 + (f + q) % 3, 2'(f), 1'(q));
      while (exp_q.size() > 0) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      check(irq, 1'b1);
      apb(1'b0, REG_PKT_INFO, 32'h0, {1'b0, info});
      apb(1'b0, REG_TS_LO, 32'h0, {1'b0, ts[31:0]});
      apb(1'b0, REG_TS_HI, 32'h0, {1'b0, ts[63:32]});
      apb(1'b1, REG_IRQ_MASK, 32'h0, 33'h0);
      repeat (3) @(posedge sys_clk);
      check(irq, 1'b0);
      apb(1'b1, REG_IRQ_MASK, 32'h2, 33'h0);
      apb(1'b1, REG_IRQ_STATUS, 32'h2, 33'h0);
      repeat (3) @(posedge sys_clk);
      check(irq, 1'b0);
      $display("test packets done");
      hold <= 1'b1;
      for (int i = 0; i < 20; i++)
         send({16'h0001, 64'(i)}, 1'b1, 2'b11);
      repeat (700) @(posedge sys_clk);
      check(tready, 1'b0);
      apb(1'b0, REG_STATUS, 32'h0, 33'h1002);
      hold <= 1'b0;
      while (exp_q.size() > 0) @(posedge sys_clk);
      apb(1'b0, REG_DROP_CNT, 32'h0, 33'h0);
      $display("test backpressure done");
      {hold, ign} <= 2'b11;
      apb(1'b1, REG_CTRL, 32'h3, 33'h0);
      for (int i = 0; i < 20; i++)
         send({16'h0001, 64'(i)}, 1'b1, 2'b11);
      repeat (700) @(posedge sys_clk);
      hold <= 1'b0;
      repeat (100) @(posedge sys_clk);
      left = exp_q.size();
      check(left, 20 - FIFO_DEPTH - 1);
      apb(1'b0, REG_DROP_CNT, 32'h0, {1'b0, 32'(left)});
      apb(1'b0, REG_IRQ_STATUS, 32'h0, 33'h3);
      exp_q.delete();
      send({16'h0000, 64'h0}, 1'b1, 2'b11);
      while (exp_q.size() > 0) @(posedge sys_clk);
      apb(1'b0, REG_IRQ_STATUS, 32'h0, 33'h7);
      $display("test overflow done");
      end_sim();
   end
endmodule
bind sample_stream_input_fifo fifo_props #(.WORD_W(WORD_W)) u_props (
   .I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_STREAM_CLK(I_STREAM_CLK),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TREADY(O_TREADY),
   .O_OUT_VALID(O_OUT_VALID), .I_OUT_READY(I_OUT_READY), .O_OUT_DATA(O_OUT_DATA),
   .O_OUT_LAST(O_OUT_LAST), .O_OUT_SAMPLE_BITS(O_OUT_SAMPLE_BITS),
   .O_OUT_USER_BITS(O_OUT_USER_BITS));
`default_nettype wire
